// >>> dv/tb.sv
// Purpose : Self-checking bench for the address table access register bank
// Assumes : Zero-wait APB slave, one-cycle command engine, table starts empty
// Notes   : Each scenario is a task; bus signals change only after rising edges

`timescale 1ns/1ps
`default_nettype none

module tb;
  import atb_pkg::*;

  // ==========================================================================
  // Signals and counters
  logic        clk_sys;      // 200 MHz system clock
  logic        rstn;         // Async reset, active low
  logic        psel;         // APB select
  logic        penable;      // APB access phase
  logic        pwrite;       // APB direction
  logic [15:0] paddr;        // Byte address
  logic [31:0] pwdata;       // Write data
  logic [3:0]  pstrb;        // Byte enables
  logic [31:0] prdata;       // Read data
  logic        pready;       // Transfer done
  logic        pslverr;      // Unmapped access
  int          mismatches;   // Failed comparisons
  int          checked;      // All comparisons

  // Entry words used across scenarios; bit 26 marks valid
  localparam logic [31:0] A_LO  = 32'h3344_5501;  // Multicast bit set
  localparam logic [31:0] A_HI  = 32'h0400_1122;
  localparam logic [31:0] B_LO  = 32'h7788_99aa;
  localparam logic [31:0] B_HI  = 32'h0401_5566;
  localparam logic [31:0] B2_HI = 32'h0762_5566;  // Same key, new attributes
  localparam logic [31:0] C_LO  = 32'h0bad_f00d;
  localparam logic [31:0] C_HI  = 32'h0500_aabb;
  localparam logic [15:0] IDX_NONE = 16'h1806;    // Unmapped word

  // ==========================================================================
  // Design under test
  atb_top uut (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  // Free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // Compare and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; leaves psel high so another setup may follow at once
  task automatic xfer(input logic is_wr, input logic [15:0] idx, input logic [31:0] data,
                      input logic [3:0] strb, input logic err, output logic [31:0] rdat);
    psel    <= 1'b1;
    pwrite  <= is_wr;
    paddr   <= idx << 2;
    pwdata  <= data;
    pstrb   <= strb;
    @(posedge clk_sys);
    // No answer may come before the access phase
    chk({31'h0, pready}, 32'h0);
    penable <= 1'b1;
    @(posedge clk_sys);
    // Wait for the answer; only the watchdog ends a dead slave
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rdat = prdata;
    chk({31'h0, pslverr}, {31'h0, err});
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [15:0] idx, input logic [31:0] data,
                    input logic [3:0] strb = 4'hf, input logic err = 1'b0);
    logic [31:0] d;
    xfer(1'b1, idx, data, strb, err, d);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic err = 1'b0);
    logic [31:0] d;
    xfer(1'b0, idx, 32'h0, 4'h0, err, d);
    chk(d, exp);
  endtask : rd

  task automatic idle;
    psel <= 1'b0;
    @(posedge clk_sys);
  endtask : idle

  // Issue a command and watch pending rise, then fall with the command bits
  task automatic cmd(input logic [31:0] bits);
    wr(IDX_CMD, bits);
    rd(IDX_CMD_STS, 32'h1);
    rd(IDX_CMD, 32'h0);
    rd(IDX_CMD_STS, 32'h0);
    idle();
  endtask : cmd

  // Walk step: command then both read words
  task automatic get(input logic [31:0] bits, input logic [31:0] lo, input logic [31:0] hi);
    cmd(bits);
    rd(IDX_RD_LOW, lo);
    rd(IDX_RD_HIGH, hi);
    idle();
  endtask : get

  task automatic make(input logic [31:0] lo, input logic [31:0] hi);
    wr(IDX_WR_LOW, lo);
    wr(IDX_WR_HIGH, hi);
    cmd(32'h4);
  endtask : make

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rd(IDX_CMD, 32'h0);
    rd(IDX_WR_LOW, 32'h0);
    rd(IDX_WR_HIGH, 32'h0);
    rd(IDX_RD_LOW, 32'h0);
    rd(IDX_RD_HIGH, 32'h0);
    rd(IDX_CMD_STS, 32'h0);
    wr(IDX_NONE, 32'hffff_ffff, 4'hf, 1'b1);
    rd(IDX_NONE, 32'h0, 1'b1);
    idle();
    $display("test reset values done");
  endtask : t_reset

  task automatic t_words;
    wr(IDX_WR_LOW, 32'hffff_ffff);
    rd(IDX_WR_LOW, 32'hffff_ffff);
    wr(IDX_WR_HIGH, 32'hffff_ffff);
    rd(IDX_WR_HIGH, 32'h07ff_ffff);
    idle();
    $display("test write words done");
  endtask : t_words

  task automatic t_walk;
    make(A_LO, A_HI);
    make(B_LO, B_HI);
    make(C_LO, C_HI);
    get(32'h2, A_LO, A_HI);
    get(32'h1, B_LO, B_HI);
    get(32'h1, C_LO, C_HI);
    get(32'h1, 32'h0, 32'h0);
    get(32'h1, 32'h0, 32'h0);
    get(32'h2, A_LO, A_HI);
    $display("test make and walk done");
  endtask : t_walk

  task automatic t_modify;
    make(B_LO, B2_HI);
    get(32'h2, A_LO, A_HI);
    get(32'h1, B_LO, B2_HI);
    get(32'h1, C_LO, C_HI);
    get(32'h1, 32'h0, 32'h0);
    $display("test modify entry done");
  endtask : t_modify

  task automatic t_remove;
    make(A_LO, A_HI & ~32'h0400_0000);
    get(32'h2, B_LO, B2_HI);
    get(32'h1, C_LO, C_HI);
    get(32'h1, 32'h0, 32'h0);
    $display("test remove entry done");
  endtask : t_remove

  // Zero command writes and a masked command byte leave the table alone
  task automatic t_zero;
    wr(IDX_WR_LOW, 32'h1111_2222);
    wr(IDX_WR_HIGH, 32'h0400_3333);
    wr(IDX_CMD, 32'h0);
    rd(IDX_CMD_STS, 32'h0);
    rd(IDX_CMD, 32'h0);
    wr(IDX_CMD, 32'h4, 4'he);
    rd(IDX_CMD_STS, 32'h0);
    idle();
    get(32'h2, B_LO, B2_HI);
    get(32'h1, C_LO, C_HI);
    get(32'h1, 32'h0, 32'h0);
    $display("test zero command done");
  endtask : t_zero

  // ==========================================================================
  // Verdict, watchdog and main sequence
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    $display("watchdog expired at %0t", $time);
    report_and_stop();
  end

  initial begin
    mismatches = 0;
    checked    = 0;
    rstn       = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 16'h0000;
    pwdata     = 32'h0000_0000;
    pstrb      = 4'h0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_words();
    t_walk();
    t_modify();
    t_remove();
    t_zero();
    report_and_stop();
  end

endmodule : tb

`default_nettype wire

// >>> hdl/atb_table_store.sv
// Purpose : Entry storage with parallel match, free and walk lookups
// Assumes : Single writer, one entry per cycle
// Notes   : Lowest index wins every lookup

`timescale 1ns/1ps
`default_nettype none

module atb_table_store
  import atb_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  rstn,
  atb_tbl_if.store   tbl
);

  // ==========================================================================
  // Storage and per-entry flags
  logic [ENTRY_W-1:0] mem [TBL_DEPTH];   // Entries
  logic [TBL_DEPTH-1:0] match_v;         // Entry holds probe address
  logic [TBL_DEPTH-1:0] free_v;          // Entry empty
  logic [TBL_DEPTH-1:0] next_v;          // Entry eligible for the walk

  for (genvar g = 0; g < TBL_DEPTH; g++) begin : g_ent
    // Each slot clears at reset so the walk never returns stale data
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        mem[g] <= '0;
      end else if (tbl.wr_en && (tbl.wr_idx == IDX_W'(g))) begin
        mem[g] <= tbl.wr_data;
      end
    end
    // Key is the full 48-bit address
    assign match_v[g] = mem[g][ENT_VALID_POS] &&
                        ({mem[g][32 +: MAC_HI_W], mem[g][31:0]} == tbl.probe_mac);
    assign free_v[g]  = !mem[g][ENT_VALID_POS];
    assign next_v[g]  = mem[g][ENT_VALID_POS] && (START_W'(g) >= tbl.start_idx);
  end

  // ==========================================================================
  // Priority encoders, lowest index first
  always_comb begin
    tbl.hit_match = 1'b0;
    tbl.match_idx = '0;
    tbl.hit_free  = 1'b0;
    tbl.free_idx  = '0;
    tbl.hit_next  = 1'b0;
    tbl.next_idx  = '0;
    for (int i = TBL_DEPTH - 1; i >= 0; i--) begin
      if (match_v[i]) begin
        tbl.hit_match = 1'b1;
        tbl.match_idx = IDX_W'(i);
      end
      if (free_v[i]) begin
        tbl.hit_free = 1'b1;
        tbl.free_idx = IDX_W'(i);
      end
      if (next_v[i]) begin
        tbl.hit_next = 1'b1;
        tbl.next_idx = IDX_W'(i);
      end
    end
  end

  // Entry under the walk cursor
  assign tbl.next_data = mem[tbl.next_idx];

endmodule : atb_table_store

`default_nettype wire

// >>> hdl/atb_top.sv
// Purpose : APB register bank giving software access to the address table
// Assumes : Zero-wait APB slave, one clock, commands finish in one cycle
// Notes   : Commands written while one is pending are dropped
//
// What this block does
// - Command write sets pending and starts operation
// - Make stores both words where table chooses
// - Make also modifies or removes existing entries
// - Command bits self-clear as pending drops
// - Writing zero command bits does nothing
// - Get-first restarts walk, loads first valid
// - Get-next loads following valid entry
// - Low write word holds address bits 31:0
// - High write word completes the entry
// - Valid bit 26 adds or invalidates entry

`timescale 1ns/1ps
`default_nettype none

module atb_top
  import atb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  // ==========================================================================
  // Declarations
  atb_state_type       state_r;        // Command engine state
  logic [CMD_W-1:0]    cmd_r;          // Command bits, self-clearing
  logic                pend_r;         // Operation pending
  logic [31:0]         wr_low_r;       // Write word low, address 31:0
  logic [31:0]         wr_high_r;      // Write word high, rest of entry
  logic [31:0]         rd_low_r;       // Read word low
  logic [31:0]         rd_high_r;      // Read word high
  logic [START_W-1:0]  nstart_r;       // Where the next walk step begins
  logic [31:0]         prdata_r;       // Read data captured in setup
  logic                slverr_r;       // Unmapped address seen in setup
  logic                setup;          // APB setup cycle
  logic                wr_acc;         // Write taken this edge
  logic [13:0]         widx;           // Word index of the access
  logic                sel_cmd;        // Decodes
  logic                sel_wlo;
  logic                sel_whi;
  logic                sel_rlo;
  logic                sel_rhi;
  logic                sel_sts;
  logic                hit_any;        // Address is mapped
  logic [CMD_W-1:0]    cmd_bits;       // Command bits written
  logic                cmd_go;         // Accepted command
  logic                run;            // Engine executing
  logic                do_make;        // Decoded operation, make first
  logic                do_first;
  logic                do_next;
  logic                do_get;
  logic [31:0]         rd_mux;         // Register read selection

  atb_tbl_if tbl ();

  // ==========================================================================
  // Byte-lane merge for writable words
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // ==========================================================================
  // APB decode
  assign setup    = psel && !penable;
  assign pready   = psel && penable;         // Always zero wait
  assign wr_acc   = psel && penable && pwrite;
  assign widx     = paddr[15:2];             // Low two bits ignored
  assign sel_cmd  = (widx == IDX_CMD[13:0]);
  assign sel_wlo  = (widx == IDX_WR_LOW[13:0]);
  assign sel_whi  = (widx == IDX_WR_HIGH[13:0]);
  assign sel_rlo  = (widx == IDX_RD_LOW[13:0]);
  assign sel_rhi  = (widx == IDX_RD_HIGH[13:0]);
  assign sel_sts  = (widx == IDX_CMD_STS[13:0]);
  assign hit_any  = sel_cmd | sel_wlo | sel_whi | sel_rlo | sel_rhi | sel_sts;
  assign pslverr  = psel && penable && slverr_r;
  assign prdata   = prdata_r;

  // Read mux, reserved bits read zero
  always_comb begin
    rd_mux = '0;
    if (sel_cmd) begin
      rd_mux[CMD_W-1:0] = cmd_r;
    end else if (sel_wlo) begin
      rd_mux = wr_low_r;
    end else if (sel_whi) begin
      rd_mux = wr_high_r;
    end else if (sel_rlo) begin
      rd_mux = rd_low_r;
    end else if (sel_rhi) begin
      rd_mux = rd_high_r;
    end else if (sel_sts) begin
      rd_mux[STS_PEND_BIT] = pend_r;
    end
  end

  // Read data and error caught in setup so the outputs come from flops
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= '0;
      slverr_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      slverr_r <= !hit_any;
    end
  end

  // ==========================================================================
  // Write data words
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_low_r  <= WR_LOW_RST;
      wr_high_r <= WR_HIGH_RST;
    end else if (wr_acc) begin
      if (sel_wlo) begin
        wr_low_r <= merge(wr_low_r, pwdata, pstrb);
      end
      if (sel_whi) begin
        wr_high_r <= merge(wr_high_r, pwdata, pstrb) & HI_RW_MASK;
      end
    end
  end

  // ==========================================================================
  // Command intake; zero bits never start anything
  assign cmd_bits = pstrb[0] ? pwdata[CMD_W-1:0] : '0;
  // A command while busy is dropped rather than queued
  assign cmd_go   = wr_acc && sel_cmd && (cmd_bits != '0) &&
                    (state_r == ST_IDLE);
  assign run      = (state_r == ST_RUN);
  // Several bits at once: make wins, then first, then next
  assign do_make  = run && cmd_r[CMD_MAKE_BIT];
  assign do_first = run && !cmd_r[CMD_MAKE_BIT] && cmd_r[CMD_FIRST_BIT];
  assign do_next  = run && (cmd_r[CMD_MAKE_BIT:CMD_FIRST_BIT] == 2'b00) &&
                    cmd_r[CMD_NEXT_BIT];
  assign do_get   = do_first || do_next;

  // Engine state, every operation takes one run cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (cmd_go) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Command bits and pending rise together and fall together
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmd_r  <= '0;
      pend_r <= 1'b0;
    end else if (cmd_go) begin
      cmd_r  <= cmd_bits;
      pend_r <= 1'b1;
    end else if (run) begin
      cmd_r  <= '0;
      pend_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Table requests
  assign tbl.probe_mac = {wr_high_r[MAC_HI_W-1:0], wr_low_r};
  assign tbl.start_idx = cmd_r[CMD_FIRST_BIT] ? '0 : nstart_r;
  // Existing entry is rewritten in place, new one takes the lowest free slot
  assign tbl.wr_idx    = tbl.hit_match ? tbl.match_idx : tbl.free_idx;
  // Clearing valid on an absent address stores nothing
  assign tbl.wr_en     = do_make && (tbl.hit_match ||
                         (wr_high_r[HI_VALID_BIT] && tbl.hit_free));
  assign tbl.wr_data   = {wr_high_r, wr_low_r};

  atb_table_store u_store (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .tbl     (tbl)
  );

  // ==========================================================================
  // Walk cursor and read data words
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_low_r  <= RD_DATA_RST;
      rd_high_r <= RD_DATA_RST;
      nstart_r  <= '0;
    end else if (do_get) begin
      if (tbl.hit_next) begin
        rd_low_r  <= tbl.next_data[31:0];
        rd_high_r <= tbl.next_data[63:32];
        nstart_r  <= START_W'(tbl.next_idx) + START_W'(1);
      end else begin
        // End of table: zero data, valid bit low tells software
        rd_low_r  <= RD_DATA_RST;
        rd_high_r <= RD_DATA_RST;
        nstart_r  <= START_W'(TBL_DEPTH);
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_go_pend;
    cmd_go |=> pend_r && (cmd_r != '0) ##1 !pend_r;
  endproperty
  a_go_pend: assert property (p_go_pend) else $error("pending not one cycle");

  property p_make_store;
    do_make && wr_high_r[HI_VALID_BIT] && tbl.hit_free && !tbl.hit_match
      |-> tbl.wr_en && (tbl.wr_idx == tbl.free_idx);
  endproperty
  a_make_store: assert property (p_make_store) else $error("make lost entry");

  property p_make_modify;
    do_make && tbl.hit_match |-> tbl.wr_en && (tbl.wr_idx == tbl.match_idx);
  endproperty
  a_make_modify: assert property (p_make_modify) else $error("make missed match");

  property p_self_clear;
    $fell(pend_r) |-> (cmd_r == '0) && $past(cmd_r != '0);
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("command not cleared");

  property p_zero_write;
    wr_acc && sel_cmd && (cmd_bits == '0) && !pend_r |=> !pend_r && (cmd_r == '0);
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write acted");

  property p_first_load;
    do_first && tbl.hit_next |=> (rd_low_r == $past(tbl.next_data[31:0])) &&
      (nstart_r == START_W'($past(tbl.next_idx)) + START_W'(1));
  endproperty
  a_first_load: assert property (p_first_load) else $error("get-first load");

  property p_next_adv;
    do_next && tbl.hit_next |-> (START_W'(tbl.next_idx) >= nstart_r)
      ##1 (rd_high_r == $past(tbl.next_data[63:32]));
  endproperty
  a_next_adv: assert property (p_next_adv) else $error("get-next order");

  property p_low_word;
    wr_acc && sel_wlo && (pstrb == 4'hf) |=> wr_low_r == $past(pwdata);
  endproperty
  a_low_word: assert property (p_low_word) else $error("low word not stored");

  // Once the clearing make has run, the same address must no longer match
  property p_invalidate;
    do_make && !wr_high_r[HI_VALID_BIT] |=> !tbl.hit_match;
  endproperty
  a_invalidate: assert property (p_invalidate) else $error("invalidate kept valid");

  property p_walk_end;
    do_get && !tbl.hit_next |=> !pend_r && (rd_high_r == RD_DATA_RST);
  endproperty
  a_walk_end: assert property (p_walk_end) else $error("walk end hang");

  c_make:  cover property (do_make && tbl.hit_match);
  c_first: cover property (do_first && tbl.hit_next);
  c_end:   cover property (do_next && !tbl.hit_next);
  c_drop:  cover property (wr_acc && sel_cmd && pend_r);

endmodule : atb_top

`default_nettype wire

// >>> pkg/atb_pkg.sv
// Purpose : Constants and types for the address lookup table access block
// Assumes : 32-bit APB, one register per aligned word, byte address = 4 * index
// Notes   : Table depth is a local sizing choice

package atb_pkg;

  // ==========================================================================
  // Table geometry
  localparam int TBL_DEPTH = 16;           // Entries held
  localparam int IDX_W     = 4;            // Entry index width
  localparam int START_W   = 5;            // Search start, one past last entry
  localparam int ENTRY_W   = 64;           // Both data words side by side
  localparam int MAC_HI_W  = 16;           // Upper address bits in high word

  // ==========================================================================
  // Register indices (byte address = index * 4)
  localparam logic [15:0] IDX_CMD     = 16'h1800;
  localparam logic [15:0] IDX_WR_LOW  = 16'h1801;
  localparam logic [15:0] IDX_WR_HIGH = 16'h1802;
  localparam logic [15:0] IDX_RD_LOW  = 16'h1803;
  localparam logic [15:0] IDX_RD_HIGH = 16'h1804;
  localparam logic [15:0] IDX_CMD_STS = 16'h1805;

  // ==========================================================================
  // Field positions and reset values
  localparam int CMD_W         = 3;        // Command bits 2:0
  localparam int CMD_MAKE_BIT  = 2;
  localparam int CMD_FIRST_BIT = 1;
  localparam int CMD_NEXT_BIT  = 0;
  localparam int STS_PEND_BIT  = 0;
  localparam int HI_VALID_BIT  = 26;
  localparam int ENT_VALID_POS = 32 + HI_VALID_BIT;
  localparam logic [31:0] HI_RW_MASK   = 32'h07ff_ffff;  // Bits 31:27 read zero
  localparam logic [31:0] WR_LOW_RST   = 32'h0000_0000;
  localparam logic [31:0] WR_HIGH_RST  = 32'h0000_0000;
  localparam logic [31:0] RD_DATA_RST  = 32'h0000_0000;

  // Command engine states
  typedef enum logic {ST_IDLE, ST_RUN} atb_state_type;

endpackage : atb_pkg

// >>> pkg/atb_tbl_if.sv
// Purpose : Carrier between the command engine and the table store
// Assumes : Same clock on both ends
// Notes   : Lookups are combinational, writes land on the next edge

`timescale 1ns/1ps
`default_nettype none

interface atb_tbl_if;
  import atb_pkg::*;

  // ==========================================================================
  // Request side
  logic                 wr_en;      // Store one entry
  logic [IDX_W-1:0]     wr_idx;     // Slot to store into
  logic [ENTRY_W-1:0]   wr_data;    // Entry contents
  logic [47:0]          probe_mac;  // Address searched for
  logic [START_W-1:0]   start_idx;  // First slot the walk may return
  // Answer side
  logic                 hit_match;  // Valid entry with probe address
  logic [IDX_W-1:0]     match_idx;
  logic                 hit_free;   // Some slot is empty
  logic [IDX_W-1:0]     free_idx;
  logic                 hit_next;   // Valid entry at or after start
  logic [IDX_W-1:0]     next_idx;
  logic [ENTRY_W-1:0]   next_data;

  modport ctrl  (output wr_en, wr_idx, wr_data, probe_mac, start_idx,
                 input  hit_match, match_idx, hit_free, free_idx,
                        hit_next, next_idx, next_data);
  modport store (input  wr_en, wr_idx, wr_data, probe_mac, start_idx,
                 output hit_match, match_idx, hit_free, free_idx,
                        hit_next, next_idx, next_data);
endinterface : atb_tbl_if

`default_nettype wire
